// ===== pss_sram.sv
// pipelined synchronous sram core with burst counter and write buffer
`timescale 1ns/100ps

// Summary of operation
// [R1] A load edge ends any burst and captures a fresh address and control.
// [R2] During a burst the write select is ignored and direction stays.
// [R3] A burst steps only the low two address bits, linear or interleaved.
// [R4] A write starts only when write select and load are both low.
// [R5] Lane enables come one cycle ahead of the data word they belong to.
// [R6] The controller keeps lane enables valid on every write beat.
// [R7] A gated clock edge is ignored and every register except the two reset release flops holds its value.
// [R8] Any chip select inactive at a load starts a deselect cycle.
// [R9] Selects are low, high, low active and switch together.
// [R10] Lanes three and four only act in the 36-bit organisation.
// [R11] Data moves on the bus two cycles after its access is loaded.
module pss_sram (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        clockGateN,
    input  wire logic [pss_pkg::ADDR_W-1:0]  addr,
    input  wire logic                        loadOrAdvance,
    input  wire logic                        writeSelectN,
    input  wire logic                        chipSelectN,
    input  wire logic                        chipSelectSecond,
    input  wire logic                        chipSelectThirdN,
    input  wire logic                        burstInterleave,
    input  wire logic [1:0]                  byteLaneWriteN,
    input  wire logic                        laneThreeWriteN,
    input  wire logic                        laneFourWriteN,
    input  wire logic [pss_pkg::DATA_W-1:0]  dqIn,
    output logic      [pss_pkg::DATA_W-1:0]  dqOut,
    output logic                             dqOe,
    output logic                             wrBufReady
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic [1:0] rstSync_q;
    logic       rstN;

    // async assert, two-flop release; every core flop leaves reset on the
    // same edge, two edges after the pin rises
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    pss_pkg::pss_core_t              st_q, st_d;
    logic                            run;
    logic                            selected;
    logic [pss_pkg::BEAT_W-1:0]      lowBits;
    logic [pss_pkg::ADDR_W-1:0]      beatAddr;
    logic [pss_pkg::LANES-1:0]       laneN;
    logic                            pushValid;
    logic [pss_pkg::WBUF_W-1:0]      pushData;
    logic                            drainValid;
    logic                            drainReady;
    logic [pss_pkg::WBUF_W-1:0]      drainData;
    logic [pss_pkg::ADDR_W-1:0]      drainAddr;
    logic [pss_pkg::DATA_W-1:0]      drainWord;
    logic [pss_pkg::LANES-1:0]       drainLaneN;
    logic                            selFirst;
    logic                            selSecond;
    logic                            selThird;
    logic                            drainFire;
    logic [pss_pkg::DATA_W-1:0]      mergedWord;

    // array is declared here; 256K words of 36 bits
    logic [pss_pkg::DATA_W-1:0] mem [0:(1 << pss_pkg::ADDR_W)-1];

    // ------------------------------------------------------------------
    // decode of pins
    // ------------------------------------------------------------------
    // a high gate pin swallows the edge
    assign run      = !clockGateN;                                  // [R7]
    // select polarities: low, high, low active
    assign selFirst  = !chipSelectN;
    assign selSecond = chipSelectSecond;
    assign selThird  = !chipSelectThirdN;
    // any inactive select deselects the device; a deselect at a load ends
    // the burst, while beats already past the address stage still finish
    assign selected  = selFirst && selSecond && selThird;           // [R8]

    // burst stepping touches only the two low bits: interleaved is base
    // xor beat, linear is base plus beat wrapping inside two bits
    always_comb begin
        if (burstInterleave) begin
            lowBits = st_q.accBase[1:0] ^ st_q.accBeat;             // [R3]
        end else begin
            lowBits = st_q.accBase[1:0] + st_q.accBeat;             // [R3]
        end
        beatAddr = {st_q.accBase[pss_pkg::ADDR_W-1:2], lowBits};
    end

    // lanes three and four only in the wide organisation
    generate
        if (pss_pkg::WIDE_ORG) begin : g_wide
            assign laneN = {laneFourWriteN, laneThreeWriteN,
                            byteLaneWriteN};                        // [R10]
        end else begin : g_narrow
            // narrow style: lanes three and four forced off
            assign laneN = {2'h3, byteLaneWriteN};                  // [R10]
        end
    endgenerate

    // ------------------------------------------------------------------
    // pipeline next state
    // ------------------------------------------------------------------
    // stage acc: the beat on the address side; stage stg: one cycle on,
    // where the lane enables arrive; the bus stage follows one later
    // nothing moves on a gated edge, so a suspend leaves the pipe and the
    // burst counter as they were; the price of no dead cycle between
    // reads and writes is the write buffer below
    always_comb begin
        st_d = st_q;
        if (run) begin
            // address stage: load or advance
            if (!loadOrAdvance) begin
                // a deselect clears the address stage only
                st_d.accValid = selected;                           // [R8]
                st_d.accWrite = !writeSelectN;                      // [R4]
                st_d.accBase  = addr;                               // [R1]
                st_d.accBeat  = pss_pkg::BEAT_RST;                  // [R1]
            end else if (st_q.accValid) begin
                // write select ignored, direction kept
                st_d.accBeat  = st_q.accBeat + 1'b1;                // [R2]
            end
            // enables sampled one cycle after the beat's address edge
            st_d.stgValid = st_q.accValid;
            st_d.stgWrite = st_q.accWrite;
            st_d.stgAddr  = beatAddr;
            st_d.stgLaneN = laneN;                                  // [R5]
            // bus stage: read word driven two cycles after load
            st_d.rdOe     = st_q.stgValid && !st_q.stgWrite;        // [R11]
            if (st_q.stgValid && !st_q.stgWrite) begin
                st_d.rdData = mem[st_q.stgAddr];                    // [R11]
            end
        end
    end

    // single state register; reset leaves the bus undriven and every
    // lane disabled
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            st_q <= '{accValid: 1'b0, accWrite: 1'b0,
                      accBase: pss_pkg::ADDR_RST,
                      accBeat: pss_pkg::BEAT_RST,
                      stgValid: 1'b0, stgWrite: 1'b0,
                      stgAddr: pss_pkg::ADDR_RST,
                      stgLaneN: pss_pkg::LANE_OFF,
                      rdData: pss_pkg::DATA_RST, rdOe: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register, no logic behind them
    assign dqOut = st_q.rdData;
    assign dqOe  = st_q.rdOe;

    // ------------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------------
    // write word taken two cycles after load, paired with the enables
    // captured one cycle earlier
    assign pushValid = run && st_q.stgValid && st_q.stgWrite;       // [R11]
    assign pushData  = {st_q.stgAddr, dqIn, st_q.stgLaneN};         // [R5]
    // a suspended edge must not retire buffered writes either
    assign drainReady = run;                                        // [R7]
    // a held word drains on every live edge and at most one fills, so the
    // buffer holds one word at most and never refuses a push

    // buffer runs on the released reset copy like the rest of the core

    pss_fifo #(
        .WIDTH (pss_pkg::WBUF_W),
        .DEPTH (pss_pkg::WBUF_DEPTH)
    ) u_wbuf (
        .clk      (clk),
        .rst_n    (rstN),
        .inValid  (pushValid),
        .inReady  (wrBufReady),
        .inData   (pushData),
        .outValid (drainValid),
        .outReady (drainReady),
        .outData  (drainData)
    );

    assign drainAddr  = drainData[pss_pkg::WBUF_W-1 -: pss_pkg::ADDR_W];
    assign drainWord  = drainData[pss_pkg::LANES +: pss_pkg::DATA_W];
    assign drainLaneN = drainData[pss_pkg::LANES-1:0];

    // ------------------------------------------------------------------
    // array write, one word per live edge
    // ------------------------------------------------------------------
    // limitation: a read loaded on the live edge right after a write to the same
    // word sees the older contents, since the write retires from the buffer
    assign drainFire = drainValid && drainReady;

    // per lane: new byte where its enable is low, old byte otherwise; one
    // writer process keeps the array single-driven
    generate
        for (genvar ln = 0; ln < pss_pkg::LANES; ln++) begin : g_lane
            assign mergedWord[ln*pss_pkg::LANE_W +: pss_pkg::LANE_W] =
                drainLaneN[ln]                                      // [R5]
                    ? mem[drainAddr][ln*pss_pkg::LANE_W +: pss_pkg::LANE_W]
                    : drainWord[ln*pss_pkg::LANE_W +: pss_pkg::LANE_W];
        end
    endgenerate

    // whole word written back; untouched lanes carry their old bytes
    always_ff @(posedge clk) begin
        if (drainFire) begin
            mem[drainAddr] <= mergedWord;
        end
    end

endmodule // pss_sram

// ===== pss_pkg.sv
// shared constants and state types for the pipelined synchronous sram
package pss_pkg;

    // ------------------------------------------------------------------
    // organisation
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 18;            // 256K words
    localparam int DATA_W    = 36;            // 36-bit organisation
    localparam int LANES     = 4;             // byte lanes at 36 bits
    localparam int LANE_W    = 9;             // bits per lane
    localparam int BEAT_W    = 2;             // two-bit burst counter
    localparam bit WIDE_ORG  = 1'b1;          // 0 selects 18-bit style lanes
    localparam int NARROW_LANES = 2;          // lanes live in narrow style

    // ------------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------------
    localparam int WBUF_DEPTH = 8;
    localparam int WBUF_W     = ADDR_W + DATA_W + LANES;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
    localparam logic [LANES-1:0]  LANE_OFF = 4'hF;  // all lanes disabled
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;

    // ------------------------------------------------------------------
    // pipeline state of the memory core
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                accValid;   // access in address stage
        logic                accWrite;   // direction fixed at load
        logic [ADDR_W-1:0]   accBase;    // base address of burst
        logic [BEAT_W-1:0]   accBeat;    // burst counter
        logic                stgValid;   // access one cycle on
        logic                stgWrite;
        logic [ADDR_W-1:0]   stgAddr;
        logic [LANES-1:0]    stgLaneN;   // lane enables, active low
        logic [DATA_W-1:0]   rdData;     // read data register
        logic                rdOe;       // bus drive enable
    } pss_core_t;

    typedef struct packed {
        logic [2:0] wrPtr;
        logic [2:0] rdPtr;
        logic [3:0] count;
    } pss_fifo_t;

endpackage

// ===== pss_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps

module pss_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);

    localparam int PW = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0]    wrPtr_q, rdPtr_q;
    logic [PW:0]      count_q;
    logic             push, pop;

    // handshakes from honest occupancy
    assign inReady  = (count_q != DEPTH[PW:0]);
    assign outValid = (count_q != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = store[rdPtr_q];

    // pointer and occupancy update
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    // data storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr_q] <= inData;
        end
    end

endmodule // pss_fifo

// ===== pss_sram_asserts.sv
// bus-pin assertions for the pipelined synchronous sram
`timescale 1ns/100ps
module pss_sram_asserts (
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       clockGateN,
    input wire logic                       loadOrAdvance,
    input wire logic                       writeSelectN,
    input wire logic                       chipSelectN,
    input wire logic                       chipSelectSecond,
    input wire logic                       chipSelectThirdN,
    input wire logic [pss_pkg::DATA_W-1:0] dqOut,
    input wire logic                       dqOe
);
    // ------
    // access kinds at a live edge
    // ------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic selOn = !chipSelectN && chipSelectSecond && !chipSelectThirdN;
    wire logic ldOn  = !clockGateN && !loadOrAdvance;
    wire logic advOn = !clockGateN && loadOrAdvance;
    sequence s_rd; ldOn && selOn && writeSelectN; endsequence
    sequence s_wr; ldOn && selOn && !writeSelectN; endsequence
    // two ungated edges carry an access to the data bus
    sequence s_live2; !clockGateN ##1 !clockGateN; endsequence

    // ------
    // checks
    // ------
    a_gate_holds:
        assert property (clockGateN |=> $stable(dqOut) && $stable(dqOe))
        else $error("outputs moved on a gated edge");
    a_read_answer:
        assert property (s_rd ##1 s_live2 |=> dqOe)
        else $error("read data not driven two edges after load");
    a_write_quiet:
        assert property (s_wr ##1 s_live2 |=> !dqOe)
        else $error("bus driven for a write slot");
    a_desel_quiet:
        assert property (ldOn && !selOn ##1 s_live2 |=> !dqOe)
        else $error("bus driven for a deselect slot");
    a_rd_burst_dir:
        assert property (s_rd ##1 advOn && !writeSelectN ##1 s_live2
                         |=> dqOe)
        else $error("read burst beat turned into a write");
    a_wr_burst_dir:
        assert property (s_wr ##1 advOn && writeSelectN ##1 s_live2
                         |=> !dqOe)
        else $error("write burst beat turned into a read");
    a_gated_delay:
        assert property (s_rd ##1 clockGateN ##1 s_live2 |=> dqOe)
        else $error("gated edge did not postpone read data");
    a_reload_read:
        assert property (s_rd ##1 advOn ##1 s_rd ##1 s_live2 |=> dqOe)
        else $error("load in a burst did not start a new read");
endmodule // pss_sram_asserts

bind pss_sram pss_sram_asserts i_pss_sram_asserts (
    .clk(clk), .rst_n(rst_n), .clockGateN(clockGateN),
    .loadOrAdvance(loadOrAdvance), .writeSelectN(writeSelectN),
    .chipSelectN(chipSelectN), .chipSelectSecond(chipSelectSecond),
    .chipSelectThirdN(chipSelectThirdN), .dqOut(dqOut), .dqOe(dqOe));

// ===== pss_host_model.sv
// host controller model driving the sram bus pins
`timescale 1ns/100ps
module pss_host_model (
    input  wire logic                   clk,
    output logic                        clockGateN,
    output logic [pss_pkg::ADDR_W-1:0]  addr,
    output logic                        loadOrAdvance,
    output logic                        writeSelectN,
    output logic                        chipSelectN,
    output logic                        chipSelectSecond,
    output logic                        chipSelectThirdN,
    output logic                        burstInterleave,
    output logic [1:0]                  byteLaneWriteN,
    output logic                        laneThreeWriteN,
    output logic                        laneFourWriteN,
    output logic [pss_pkg::DATA_W-1:0]  dqIn
);
    // ------
    // pin driving
    // ------
    // one cycle of pins; data not owned this cycle shows its inverse
    task automatic drive(input logic g, input logic ld, input logic ws,
                         input logic sel, input logic m,
                         input logic [pss_pkg::ADDR_W-1:0] a,
                         input logic [3:0] ln, input logic dv,
                         input logic [pss_pkg::DATA_W-1:0] d);
        clockGateN       = g;
        loadOrAdvance    = ld;
        writeSelectN     = ws;
        chipSelectN      = !sel;
        chipSelectSecond = sel;
        chipSelectThirdN = !sel;
        burstInterleave  = m;
        addr             = a;
        {laneFourWriteN, laneThreeWriteN, byteLaneWriteN} = ln;
        dqIn             = dv ? d : ~dqIn;
    endtask

    // pins change a fixed step after each rising edge
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    initial drive(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, '0, 4'hF, 1'b1, '0);
endmodule // pss_host_model

// ===== testbench.sv
// self-checking bench for the pipelined synchronous sram
`timescale 1ns/100ps
module testbench;
    logic                        clk, rst_n, clockGateN, loadOrAdvance;
    logic                        writeSelectN, chipSelectN, dqOe;
    logic                        chipSelectSecond, chipSelectThirdN;
    logic                        burstInterleave, laneThreeWriteN;
    logic                        laneFourWriteN, wrBufReady;
    logic [1:0]                  byteLaneWriteN;
    logic [pss_pkg::ADDR_W-1:0]  addr;
    logic [pss_pkg::DATA_W-1:0]  dqIn, dqOut;
    logic [pss_pkg::DATA_W-1:0]  mem [4];
    int                          n_errors = 0;
    int                          check_count = 0;

    pss_sram i_pss_sram (.clk(clk), .rst_n(rst_n), .clockGateN(clockGateN),
        .addr(addr), .loadOrAdvance(loadOrAdvance), .dqOe(dqOe),
        .writeSelectN(writeSelectN), .chipSelectN(chipSelectN),
        .chipSelectSecond(chipSelectSecond), .dqIn(dqIn), .dqOut(dqOut),
        .chipSelectThirdN(chipSelectThirdN), .wrBufReady(wrBufReady),
        .burstInterleave(burstInterleave), .byteLaneWriteN(byteLaneWriteN),
        .laneThreeWriteN(laneThreeWriteN), .laneFourWriteN(laneFourWriteN));
    pss_host_model i_pss_host_model (.clk(clk), .clockGateN(clockGateN),
        .addr(addr), .loadOrAdvance(loadOrAdvance), .dqIn(dqIn),
        .writeSelectN(writeSelectN), .chipSelectN(chipSelectN),
        .chipSelectSecond(chipSelectSecond), .burstInterleave(burstInterleave),
        .chipSelectThirdN(chipSelectThirdN), .byteLaneWriteN(byteLaneWriteN),
        .laneThreeWriteN(laneThreeWriteN), .laneFourWriteN(laneFourWriteN));

    always #2.5 clk = ~clk;

    // ------
    // helpers
    // ------
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // nb beats, then loads of base (tl=1) or deselects; g gates one edge
    task automatic xfer(input logic w, input logic m, input logic [17:0] b,
                        input int nb, input logic [15:0] ln,
                        input logic [35:0] pat, input logic g,
                        input logic tl);
        logic [1:0]  ix;
        logic [3:0]  lw;
        logic [35:0] d, o;
        logic        eo;
        int          k;
        for (int c = 0; c < 8; c++) begin
            k  = c - 2;
            ix = m ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k);
            d  = pat + 36'(k) * 36'h0_1111_1111;
            lw = (w && c >= 1 && c <= nb) ? ln[4*c-4+:4] : 4'hF;
            i_pss_host_model.drive(1'b0, c > 0 && c < nb,
                c == 0 ? !w : (c < nb ? w : 1'b1), c < nb || tl, m,
                (c > 0 && c < nb) ? ~b : b, lw, w && k >= 0 && k < nb, d);
            i_pss_host_model.tick();
            if (g && c == 0) begin
                o = dqOut;
                i_pss_host_model.drive(1'b1, 1'b0, 1'b0, 1'b1, !m, ~b,
                                       4'h0, 1'b1, ~d);
                i_pss_host_model.tick();
                chk(dqOut, o);
            end
            chk(wrBufReady, 36'h1);
            if (k >= 0) begin
                eo = !w && (k < nb || tl);
                chk(dqOe, eo);
                if (eo) chk(dqOut, mem[k < nb ? ix : b[1:0]]);
                for (int j = 0; j < 4; j++) begin
                    if (w && k < nb && !ln[4*k+j]) mem[ix][9*j+:9] = d[9*j+:9];
                end
            end
        end
    endtask

    // ------
    // scenarios
    // ------
    task automatic sc_fill();
        xfer(1, 0, 18'h0_0121, 4, 16'h0000, 36'hA_5A5A_5A50, 0, 0);
    endtask
    task automatic sc_lanes();
        xfer(1, 1, 18'h0_0122, 4, 16'h7BDE, 36'h3_C3C3_C3C0, 0, 0);
    endtask
    task automatic sc_read_lin();
        xfer(0, 0, 18'h0_0123, 4, 16'hFFFF, 36'h0, 0, 0);
    endtask
    task automatic sc_read_gated();
        xfer(0, 1, 18'h0_0120, 4, 16'hFFFF, 36'h0, 1, 0);
    endtask
    task automatic sc_desel();
        xfer(0, 0, 18'h0_0121, 2, 16'hFFFF, 36'h0, 0, 0);
    endtask
    task automatic sc_reload();
        xfer(0, 1, 18'h0_0122, 2, 16'hFFFF, 36'h0, 0, 1);
    endtask

    initial begin
        clk   = 1'b0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) i_pss_host_model.tick();
        sc_fill();
        sc_lanes();
        sc_read_lin();
        sc_read_gated();
        sc_desel();
        sc_reload();
        print_verdict();
    end

    // hang guard
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
endmodule // testbench
